/* File: pscfg_pkg.sv */
// Package with constants and types for the PHY self-ID configuration block.
package pscfg_pkg;
    // ==========================================================
    // Field widths and reset values
    localparam int          PSCFG_PWR_W        = 3;
    localparam int          PSCFG_SPD_W        = 2;
    localparam int          PSCFG_GAP_W        = 6;
    localparam logic [1:0]  PSCFG_SPD_S100     = 2'h0;
    localparam logic [1:0]  PSCFG_SPD_S200     = 2'h1;
    localparam logic [1:0]  PSCFG_SPD_S400     = 2'h2;
    localparam logic [1:0]  PSCFG_SPD_MAX      = PSCFG_SPD_S400;
    localparam logic [2:0]  PSCFG_PWR_RESERVED = 3'h5;
    localparam logic [5:0]  PSCFG_GAP_MAX      = 6'h3f;
    // ==========================================================
    // Long request speed codes above this are unsupported.
    localparam logic [2:0]  PSCFG_LSPD_MAX     = 3'h2;
    // Request bit lengths, including the start bit.
    localparam logic [3:0]  PSCFG_SHORT_LEN    = 4'h7;
    localparam logic [3:0]  PSCFG_LONG_LEN     = 4'h8;
    localparam logic [3:0]  PSCFG_REG_LEN      = 4'h8;
    // Request type codes carried in the three bits after the start bit.
    localparam logic [2:0]  PSCFG_RT_SHORT     = 3'h0;
    localparam logic [2:0]  PSCFG_RT_LONG      = 3'h3;
    localparam logic [2:0]  PSCFG_RT_REG       = 3'h5;
    // Null packet length in cycles: one data-prefix, one data-end.
    localparam logic [1:0]  PSCFG_NULL_CYC     = 2'h2;

    typedef enum logic [1:0] {
        PSCFG_TX_IDLE,
        PSCFG_TX_PREFIX,
        PSCFG_TX_END
    } pscfg_tx_t;
endpackage : pscfg_pkg

/* File: pscfg_req_if.sv */
// Interface carrying decoded link requests between the deserialiser and the top.
`timescale 1ns/10ps
interface pscfg_req_if;
    logic       req_valid;
    logic [2:0] req_type;
    logic [2:0] req_speed;
    logic       req_long;
    logic [3:0] req_arg;
    modport src (output req_valid, output req_type, output req_speed, output req_long, output req_arg);
    modport dst (input  req_valid, input  req_type, input  req_speed, input  req_long, input  req_arg);
endinterface : pscfg_req_if

/* File: pscfg_req_dec.sv */
// Serial link request deserialiser for short and long bus requests.
`timescale 1ns/10ps
module pscfg_req_dec
    import pscfg_pkg::*;
(
    input  wire logic   i_clk,
    input  wire logic   i_reset,
    input  wire logic   i_lreq,
    pscfg_req_if.src    req
);
    // ==========================================================
    // Shift register and bit counter
    logic [7:0] shift_q;
    logic [3:0] cnt_q;
    logic       busy_q;
    logic       valid_q;
    logic [2:0] type_q;
    logic [2:0] spd_q;
    logic       long_q;
    logic [3:0] arg_q;

    // The count includes the start bit. While the seventh bit arrives, where a short
    // request may end, the type field sits one place lower than a bit later.
    wire  [7:0] shift_n  = {shift_q[6:0], i_lreq};
    wire  [3:0] cnt_n    = cnt_q + 4'h1;
    wire        at_short = (cnt_q == (PSCFG_SHORT_LEN - 4'h1));
    wire  [2:0] htype    = at_short ? shift_q[4:2] : shift_q[5:3];
    wire  [3:0] tlen     = (htype == PSCFG_RT_SHORT) ? PSCFG_SHORT_LEN :
                           (htype == PSCFG_RT_LONG)  ? PSCFG_LONG_LEN  : PSCFG_REG_LEN;
    wire        done     = busy_q && (cnt_q >= (PSCFG_SHORT_LEN - 4'h1)) && (cnt_n == tlen);
    // Fields of the finished frame; a short frame is one bit shorter than the others.
    wire        is_short = (tlen == PSCFG_SHORT_LEN);
    wire  [2:0] ftype    = is_short ? shift_n[5:3] : shift_n[6:4];
    wire  [2:0] fspd     = is_short ? {1'b0, shift_n[2:1]} : shift_n[3:1];

    // Busy clears on the exact last bit, so a request that
    // starts in the very next cycle after a short one is not merged.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            shift_q <= 8'h00;
            cnt_q   <= 4'h0;
            busy_q  <= 1'b0;
            valid_q <= 1'b0;
            type_q  <= 3'h0;
            spd_q   <= 3'h0;
            long_q  <= 1'b0;
            arg_q   <= 4'h0;
        end else begin
            valid_q <= done;
            if (!busy_q) begin
                shift_q <= 8'h00;
                busy_q  <= i_lreq;
                cnt_q   <= 4'h1;
            end else if (done) begin
                busy_q  <= 1'b0;
                type_q  <= ftype;
                long_q  <= (ftype == PSCFG_RT_LONG);
                // Short requests carry two speed bits, long ones three.
                spd_q   <= fspd;
                arg_q   <= shift_n[3:0];
            end else begin
                shift_q <= shift_n;
                cnt_q   <= cnt_n;
            end
        end
    end

    assign req.req_valid = valid_q;
    assign req.req_type  = type_q;
    assign req.req_speed = spd_q;
    assign req.req_long  = long_q;
    assign req.req_arg   = arg_q;

    // Helper that checks each decode is a one-cycle valid pulse.
    a_one_pulse: assert property (@(posedge i_clk) disable iff (i_reset)
        valid_q |=> !valid_q) else $error("request valid held two cycles");
endmodule : pscfg_req_dec

/* File: pscfg_top.sv */
// PHY self-ID configuration, request decode and bus reset control.
//
// Contract
// - Default power class comes from strap pins.
// - Hard reset loads straps; later writes override.
// - Power class codes pass unchanged; 101 reserved.
// - Decode short and long bus requests.
// - Back to back requests decode separately.
// - Long request above max speed sends null.
// - Received packet data always forwarded to link.
// - Link speed only changes self-ID speed field.
// - Link speed defaults to maximum at reset.
// - Bus reset request bit starts bus reset.
// - Reset bit write also writes holdoff, gap.
// - Link speed 00 low, 01 mid, 10 high.
// - Software hard reset equals hardware reset; reads zero.
// - Two resets without gap write force 63.
// - Config packets sent or received load holdoff, gap.
`timescale 1ns/10ps
module pscfg_top
    import pscfg_pkg::*;
(
    input  wire logic                   i_clk,
    input  wire logic                   i_reset,
    input  wire logic                   i_reset_pin_n,
    input  wire logic [PSCFG_PWR_W-1:0] i_power_class_strap_pins,
    input  wire logic                   i_lreq,
    input  wire logic                   i_pwr_wr,
    input  wire logic [PSCFG_PWR_W-1:0] i_pwr_wdata,
    input  wire logic                   i_spd_wr,
    input  wire logic [PSCFG_SPD_W-1:0] i_spd_wdata,
    input  wire logic                   i_r1_wr,
    input  wire logic                   i_bus_reset_request_bit,
    input  wire logic                   i_root_holdoff_bit,
    input  wire logic [PSCFG_GAP_W-1:0] i_gap_wdata,
    input  wire logic                   i_r5_wr,
    input  wire logic                   i_arb_accel_enable_bit,
    input  wire logic                   i_multispeed_concat_enable_bit,
    input  wire logic                   i_software_hard_reset_bit,
    input  wire logic                   i_cfg_pkt,
    input  wire logic                   i_cfg_rhb,
    input  wire logic [PSCFG_GAP_W-1:0] i_cfg_gap,
    input  wire logic                   i_bus_reset_done,
    input  wire logic                   i_rx_valid,
    input  wire logic [7:0]             i_rx_data,
    output logic                        o_bus_reset_start,
    output logic [PSCFG_PWR_W-1:0]      o_selfid_pwr,
    output logic [PSCFG_SPD_W-1:0]      o_selfid_spd,
    output logic [PSCFG_SPD_W-1:0]      o_peer_spd,
    output logic                        o_root_holdoff,
    output logic [PSCFG_GAP_W-1:0]      o_gap_count,
    output logic                        o_arb_accel_en,
    output logic                        o_multispeed_en,
    output logic                        o_swr_rdata,
    output logic                        o_req_valid,
    output logic [2:0]                  o_req_type,
    output logic [2:0]                  o_req_speed,
    output logic                        o_null_prefix,
    output logic                        o_null_end,
    output logic                        o_rx_valid,
    output logic [7:0]                  o_rx_data
);
    // ==========================================================
    // Pin synchronisers
    // The reset pin, straps and link request come from outside the clock domain.
    logic       rstn_s1_q, rstn_s2_q;
    logic [2:0] strap_s1_q, strap_s2_q;
    logic       lreq_s1_q, lreq_s2_q;

    always_ff @(posedge i_clk) begin
        rstn_s1_q  <= i_reset_pin_n;
        rstn_s2_q  <= rstn_s1_q;
        strap_s1_q <= i_power_class_strap_pins;
        strap_s2_q <= strap_s1_q;
        lreq_s1_q  <= i_lreq;
        lreq_s2_q  <= lreq_s1_q;
    end

    // ==========================================================
    // Hard reset: the minimum pin width is the system's duty, not checked here.
    logic swr_q;
    wire  hard_rst = i_reset || !rstn_s2_q || swr_q;

    // The software reset acts one cycle later as a one-cycle pulse, a cycle sooner than a pin pulse through the synchroniser.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            swr_q <= 1'b0;
        end else begin
            swr_q <= i_software_hard_reset_bit && !swr_q;
        end
    end

    // ==========================================================
    // Request decoder
    pscfg_req_if req ();

    pscfg_req_dec u_dec (
        .i_clk   (i_clk),
        .i_reset (hard_rst),
        .i_lreq  (lreq_s2_q),
        .req     (req)
    );

    wire bad_speed = req.req_valid && req.req_long && (req.req_speed > PSCFG_LSPD_MAX);

    // ==========================================================
    // Configuration registers
    logic [2:0] pwr_q, pwr_live_q;
    logic [1:0] spd_q, spd_live_q;
    logic       rhb_q, ibr_q, eaa_q, emc_q, gap_wr_q, rst_seen_q;
    logic [5:0] gap_q;
    pscfg_tx_t  tx_q;

    wire gap_write = (i_r1_wr) || i_cfg_pkt;
    wire spd_ok    = (i_spd_wdata != 2'h3);

    always_ff @(posedge i_clk) begin
        if (hard_rst) begin
            pwr_q      <= strap_s2_q;
            spd_q      <= PSCFG_SPD_MAX;
            rhb_q      <= 1'b0;
            gap_q      <= PSCFG_GAP_MAX;
            eaa_q      <= 1'b0;
            emc_q      <= 1'b0;
            ibr_q      <= 1'b0;
        end else begin
            if (i_pwr_wr) pwr_q <= i_pwr_wdata;
            if (i_spd_wr && spd_ok) spd_q <= i_spd_wdata;
            if (i_r5_wr) begin
                eaa_q <= i_arb_accel_enable_bit;
                emc_q <= i_multispeed_concat_enable_bit;
            end
            ibr_q <= i_r1_wr && i_bus_reset_request_bit;
            if (i_r1_wr) begin
                rhb_q <= i_root_holdoff_bit;
                gap_q <= i_gap_wdata;
            end else if (i_cfg_pkt) begin
                rhb_q <= i_cfg_rhb;
                gap_q <= i_cfg_gap;
            end else if (i_bus_reset_done && rst_seen_q && !gap_wr_q) begin
                gap_q <= PSCFG_GAP_MAX;
            end
        end
    end

    // Tracks bus resets since the last gap-count write; the write wins over the reset.
    always_ff @(posedge i_clk) begin
        if (hard_rst) begin
            gap_wr_q   <= 1'b0;
            rst_seen_q <= 1'b0;
        end else if (gap_write) begin
            gap_wr_q   <= 1'b1;
            rst_seen_q <= 1'b0;
        end else if (i_bus_reset_done) begin
            gap_wr_q   <= 1'b0;
            rst_seen_q <= 1'b1;
        end
    end

    // Self-ID fields latch only at a bus reset so changes wait for the next one.
    always_ff @(posedge i_clk) begin
        if (hard_rst) begin
            pwr_live_q <= strap_s2_q;
            spd_live_q <= PSCFG_SPD_MAX;
        end else if (i_bus_reset_done) begin
            pwr_live_q <= pwr_q;
            spd_live_q <= spd_q;
        end
    end

    // ==========================================================
    // Null packet generator for over-speed long requests
    always_ff @(posedge i_clk) begin
        if (hard_rst) begin
            tx_q <= PSCFG_TX_IDLE;
        end else begin
            case (tx_q)
                PSCFG_TX_IDLE:   tx_q <= bad_speed ? PSCFG_TX_PREFIX : PSCFG_TX_IDLE;
                PSCFG_TX_PREFIX: tx_q <= PSCFG_TX_END;
                PSCFG_TX_END:    tx_q <= PSCFG_TX_IDLE;
                default:         tx_q <= PSCFG_TX_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Registered outputs
    always_ff @(posedge i_clk) begin
        if (hard_rst) begin
            o_req_valid <= 1'b0;
            o_req_type  <= 3'h0;
            o_req_speed <= 3'h0;
            o_rx_valid  <= 1'b0;
            o_rx_data   <= 8'h00;
            o_peer_spd    <= PSCFG_SPD_MAX;
            o_swr_rdata   <= 1'b0;
            o_null_prefix <= 1'b0;
            o_null_end    <= 1'b0;
        end else begin
            o_req_valid <= req.req_valid && !bad_speed;
            o_req_type  <= req.req_type;
            o_req_speed <= req.req_speed;
            o_rx_valid  <= i_rx_valid;
            o_rx_data   <= i_rx_data;
            o_peer_spd    <= PSCFG_SPD_MAX;
            o_swr_rdata   <= 1'b0;
            // These flops switch on the same edge as the state, so the pulses keep its timing.
            o_null_prefix <= bad_speed && (tx_q == PSCFG_TX_IDLE);
            o_null_end    <= (tx_q == PSCFG_TX_PREFIX);
        end
    end

    assign o_bus_reset_start = ibr_q;
    assign o_selfid_pwr      = pwr_live_q;
    assign o_selfid_spd      = spd_live_q;
    assign o_root_holdoff    = rhb_q;
    assign o_gap_count       = gap_q;
    assign o_arb_accel_en    = eaa_q;
    assign o_multispeed_en   = emc_q;

    // ==========================================================
    // Assertions
    sequence s_null_pkt;
        o_null_prefix ##1 o_null_end;
    endsequence

    a_null_packet: assert property (@(posedge i_clk) disable iff (hard_rst)
        bad_speed && tx_q == PSCFG_TX_IDLE |=> s_null_pkt) else $error("no null packet");
    a_ibr_pulse: assert property (@(posedge i_clk) disable iff (hard_rst)
        i_r1_wr && i_bus_reset_request_bit |=> o_bus_reset_start) else $error("no bus reset");
    a_r1_shared: assert property (@(posedge i_clk) disable iff (hard_rst)
        i_r1_wr |=> o_gap_count == $past(i_gap_wdata) && o_root_holdoff == $past(i_root_holdoff_bit))
        else $error("register 1 fields not written");
    a_gap_force: assert property (@(posedge i_clk) disable iff (hard_rst)
        i_bus_reset_done && rst_seen_q && !gap_write |=> o_gap_count == PSCFG_GAP_MAX)
        else $error("gap not forced");
    a_cfg_load: assert property (@(posedge i_clk) disable iff (hard_rst)
        i_cfg_pkt && !i_r1_wr |=> o_gap_count == $past(i_cfg_gap)) else $error("config gap lost");
    a_peer_speed: assert property (@(posedge i_clk) disable iff (i_reset)
        o_peer_spd == PSCFG_SPD_MAX) else $error("peer speed not max");
    a_self_hold: assert property (@(posedge i_clk) disable iff (hard_rst)
        !i_bus_reset_done |=> $stable(o_selfid_spd) && $stable(o_selfid_pwr))
        else $error("self-ID changed without reset");
    a_swr_zero: assert property (@(posedge i_clk) disable iff (i_reset)
        i_software_hard_reset_bit && !swr_q |=> hard_rst ##0 !o_swr_rdata) else $error("soft reset failed");
    a_rx_pass: assert property (@(posedge i_clk) disable iff (hard_rst)
        i_rx_valid |=> o_rx_valid && o_rx_data == $past(i_rx_data)) else $error("rx data dropped");
endmodule : pscfg_top

/* File: pscfg_link_model.sv */
// Behavioural link layer model that sends serial service requests to the block.
`timescale 1ns/10ps
module pscfg_link_model
    import pscfg_pkg::*;
(
    input  wire logic i_clk,
    output logic      o_lreq
);
    // ==========================================================
    // Request sender
    // The request line idles low, so a start bit of one marks every frame.
    initial o_lreq = 1'b0;
    // Sends the low len bits of frame MSB first, changing only at the falling edge.
    task automatic send(input logic [7:0] frame, input int len);
        for (int i = len - 1; i >= 0; i--) begin
            @(negedge i_clk);
            o_lreq = frame[i];
        end
    endtask : send
    // Short requests carry a two-bit speed and leave the line free one bit earlier.
    task automatic short_req(input logic [1:0] spd);
        send({1'b0, 1'b1, PSCFG_RT_SHORT, spd, 1'b0}, 7);
    endtask : short_req
    task automatic long_req(input logic [2:0] spd);
        send({1'b1, PSCFG_RT_LONG, spd, 1'b0}, 8);
    endtask : long_req
    task automatic reg_req(input logic [3:0] arg);
        send({1'b1, PSCFG_RT_REG, arg}, 8);
    endtask : reg_req
    // Releases the line one cycle after the last bit; back-to-back senders skip this.
    task automatic idle();
        @(negedge i_clk);
        o_lreq = 1'b0;
    endtask : idle
endmodule : pscfg_link_model

/* File: testbench.sv */
// Self-checking testbench for the self-ID configuration and bus reset block.
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module testbench
    import pscfg_pkg::*;
;
    // ==========================================================
    // Stimulus signals, all given a value at time zero
    logic i_clk = 0, i_reset = 1, i_reset_pin_n = 1, i_lreq, i_pwr_wr = 0, i_spd_wr = 0, i_r1_wr = 0;
    logic i_bus_reset_request_bit = 0, i_root_holdoff_bit = 0, i_r5_wr = 0, i_arb_accel_enable_bit = 0;
    logic i_multispeed_concat_enable_bit = 0, i_software_hard_reset_bit = 0, i_cfg_pkt = 0, i_cfg_rhb = 0;
    logic i_bus_reset_done = 0, i_rx_valid = 0, o_bus_reset_start, o_root_holdoff, o_arb_accel_en;
    logic o_multispeed_en, o_swr_rdata, o_req_valid, o_null_prefix, o_null_end, o_rx_valid;
    logic [2:0] i_power_class_strap_pins = 3'h6, i_pwr_wdata = 0, o_selfid_pwr, o_req_type, o_req_speed;
    logic [1:0] i_spd_wdata = 0, o_selfid_spd, o_peer_spd;
    logic [5:0] i_gap_wdata = 0, i_cfg_gap = 0, o_gap_count;
    logic [7:0] i_rx_data = 0, o_rx_data;
    logic [5:0] rq[$];
    int n_mismatch = 0, checked = 0, cyc = 0, k;
    pscfg_top i_pscfg_top (.i_clk, .i_reset, .i_reset_pin_n, .i_power_class_strap_pins, .i_lreq, .i_pwr_wr,
        .i_pwr_wdata, .i_spd_wr, .i_spd_wdata, .i_r1_wr, .i_bus_reset_request_bit, .i_root_holdoff_bit,
        .i_gap_wdata, .i_r5_wr, .i_arb_accel_enable_bit, .i_multispeed_concat_enable_bit,
        .i_software_hard_reset_bit, .i_cfg_pkt, .i_cfg_rhb, .i_cfg_gap, .i_bus_reset_done, .i_rx_valid,
        .i_rx_data, .o_bus_reset_start, .o_selfid_pwr, .o_selfid_spd, .o_peer_spd, .o_root_holdoff,
        .o_gap_count, .o_arb_accel_en, .o_multispeed_en, .o_swr_rdata, .o_req_valid, .o_req_type,
        .o_req_speed, .o_null_prefix, .o_null_end, .o_rx_valid, .o_rx_data);
    pscfg_link_model i_pscfg_link_model (.i_clk(i_clk), .o_lreq(i_lreq));
    // ==========================================================
    // Clock, timeout and decoded request capture
    initial forever #25 i_clk = ~i_clk;
    // Requests are queued so back-to-back decodes can be told apart afterwards.
    always @(posedge i_clk) begin
        cyc++;
        if (o_req_valid === 1'b1) rq.push_back({o_req_type, o_req_speed});
        if (cyc == 6000) begin
            n_mismatch++;
            stop_test();
        end
    end
    task automatic tick();
        @(negedge i_clk);
    endtask : tick
    // Every strobe is preceded by a free cycle, so no signal is driven twice in one step.
    task automatic pulse(ref logic s);
        tick();
        s = 1'b1;
        tick();
        s = 1'b0;
    endtask : pulse
    task automatic check_reset_state();
        `CHK(o_selfid_pwr, 3'h6)
        `CHK(o_selfid_spd, PSCFG_SPD_MAX)
        `CHK({o_gap_count, o_root_holdoff, o_arb_accel_en, o_multispeed_en}, {PSCFG_GAP_MAX, 3'h0})
        `CHK(o_swr_rdata, 1'b0)
    endtask : check_reset_state
    task automatic stop_test();
        if (n_mismatch == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : stop_test
    // ==========================================================
    // Main sequence
    initial begin
        repeat (16) tick();
        i_reset = 1'b0;
        check_reset_state();
        // Leaf hardware programs the speed field straight after reset.
        i_spd_wdata = 2'h1;
        pulse(i_spd_wr);
        for (int s = 0; s < 4; s++) begin
            i_spd_wdata = 2'(s);
            pulse(i_spd_wr);
            pulse(i_bus_reset_done);
            `CHK(o_selfid_spd, (s == 3) ? 2'h2 : 2'(s))
            `CHK(o_peer_spd, PSCFG_SPD_S400)
        end
        i_pwr_wdata = 3'h1;
        pulse(i_pwr_wr);
        `CHK(o_selfid_pwr, 3'h6)
        for (int p = 0; p < 8; p++) begin
            i_pwr_wdata = 3'(p);
            pulse(i_pwr_wr);
            pulse(i_bus_reset_done);
            `CHK(o_selfid_pwr, 3'(p))
        end
        i_bus_reset_request_bit = 1'b1;
        i_root_holdoff_bit = 1'b1;
        i_gap_wdata = 6'h05;
        pulse(i_r1_wr);
        `CHK({o_bus_reset_start, o_root_holdoff, o_gap_count}, {2'h3, 6'h05})
        pulse(i_bus_reset_done);
        `CHK(o_gap_count, 6'h05)
        pulse(i_bus_reset_done);
        `CHK(o_gap_count, PSCFG_GAP_MAX)
        i_cfg_rhb = 1'b0;
        i_cfg_gap = 6'h2a;
        pulse(i_cfg_pkt);
        `CHK({o_root_holdoff, o_gap_count}, {1'b0, 6'h2a})
        {i_arb_accel_enable_bit, i_multispeed_concat_enable_bit} = 2'h3;
        pulse(i_r5_wr);
        `CHK({o_arb_accel_en, o_multispeed_en}, 2'h3)
        // The modelled link lacks both features, so software clears them again.
        {i_arb_accel_enable_bit, i_multispeed_concat_enable_bit} = 2'h0;
        pulse(i_r5_wr);
        `CHK({o_arb_accel_en, o_multispeed_en}, 2'h0)
        i_spd_wdata = 2'h0;
        pulse(i_spd_wr);
        pulse(i_software_hard_reset_bit);
        tick();
        check_reset_state();
        pulse(i_spd_wr);
        // The pin pulse is far shorter than power-on needs; only the synchroniser is exercised.
        i_reset_pin_n = 1'b0;
        repeat (4) tick();
        i_reset_pin_n = 1'b1;
        repeat (4) tick();
        check_reset_state();
        // Short and long requests of every legal speed, then a short one glued to a register one.
        for (int s = 0; s < 3; s++) begin
            i_pscfg_link_model.short_req(2'(s));
            i_pscfg_link_model.long_req(3'(s));
        end
        i_pscfg_link_model.short_req(2'h1);
        i_pscfg_link_model.reg_req(4'h9);
        i_pscfg_link_model.idle();
        for (k = 0; k < 40 && rq.size() < 8; k++) tick();
        `CHK(rq.size(), 8)
        for (int s = 0; s < 6; s++) `CHK(rq[s], {(s % 2) ? PSCFG_RT_LONG : PSCFG_RT_SHORT, 3'(s / 2)})
        `CHK(rq[6], {PSCFG_RT_SHORT, 3'h1})
        `CHK(rq[7][5:3], PSCFG_RT_REG)
        for (int s = 3; s < 8; s++) begin
            i_pscfg_link_model.long_req(3'(s));
            i_pscfg_link_model.idle();
            for (k = 0; k < 40 && o_null_prefix !== 1'b1; k++) tick();
            `CHK(o_null_prefix, 1'b1)
            tick();
            `CHK({o_null_prefix, o_null_end}, 2'h1)
        end
        `CHK(rq.size(), 8)
        for (int d = 0; d < 2; d++) begin
            i_rx_data = d ? 8'hff : 8'ha5;
            i_rx_valid = 1'b1;
            tick();
            `CHK({o_rx_valid, o_rx_data}, {1'b1, i_rx_data})
        end
        i_rx_valid = 1'b0;
        tick();
        `CHK(o_rx_valid, 1'b0)
        stop_test();
    end
endmodule : testbench
